/* hw/timer_two_ctrl.sv */
/*
  Timer two: control/status register, 16-bit or split 8-bit auto-reload counter,
  capture mode, alternate clock selection and synchronisation.
  Assumes the core drives a synchronous byte-wide register port (addr, wdata,
  write strobe, bit-write strobe) and reads rdata one cycle after a read strobe.
  The timer interrupt enable lives in the core; irq_request is gated by it here.
  Per-byte fast clock selects come from the neighbouring clock control register
  and are taken as plain levels, already in the core clock domain.
  Comparator and real-time clock inputs may change at any time; each passes a
  two-stage synchroniser and only its rising edges advance anything.
  A byte write and a bit write to the control register in one cycle: the byte
  write wins. A hardware flag set in the cycle of a software clear wins.
  Register reads have no side effects; the two count bytes are not latched
  together, so software reading a running 16-bit count must allow for a carry.
  Capture is meant for 16-bit mode; in split mode it still copies and flags.
*/
//Behaviour
//- High overflow flag sets when upper byte wraps 0xff to 0x00, any mode.
//- In 16-bit mode high flag sets when whole count wraps 0xffff to 0x0000.
//- With timer interrupt enabled, a set high flag requests an interrupt.
//- Flags never clear by hardware; software writes zero to clear.
//- Low overflow flag sets when lower byte wraps, in either mode.
//- Low flag requests interrupt when low byte enable and timer interrupt are on.
//- Capture enable bit at one selects capture mode.
//- Split bit one gives two 8-bit reload counters, zero one 16-bit counter.
//- Run bit enables counting; in split mode it gates the upper byte only.
//- Selector 00/10 core clock /12, 01 comparator 0, 11 real-time clock /8.
//- Capture trigger: selector 00/01 real-time clock /8, 10/11 comparator 0.
//- In split mode the alternate clock serves both bytes, per-byte selects apply.
//- Alternate clock sources are synchronised to the core clock before use.
//- Control register bit-addressable, all pages, resets to zero.
//- 16-bit overflow reloads pair except in capture mode; split mode reloads each byte separately.
//- Capture trigger copies count to reload pair and sets high flag.
//- Per-byte select one clocks that byte from core clock, zero from alternate.
`timescale 1ns/1ps
`default_nettype none
module timer_two_ctrl
  import timer_two_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic bit_write,
  input wire logic [2:0] bit_index,
  input wire logic bit_value,
  output logic [7:0] reg_rdata,
  // Neighbouring clock control bits and core interrupt enable
  input wire logic high_byte_fast_clock_select,
  input wire logic low_byte_fast_clock_select,
  input wire logic timer_irq_enable,
  // Asynchronous sources
  input wire logic comparator0_out,
  input wire logic rtc_clock,
  // Status
  output logic irq_request,
  output logic [7:0] control_out
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] count_low;
    logic [7:0] count_high;
    logic [7:0] reload_low;
    logic [7:0] reload_high;
    logic [3:0] div12;
    logic [2:0] rtc_div;
    logic [1:0] cmp_sync;
    logic [1:0] rtc_sync;
    logic cmp_prev;
    logic rtc_prev;
    logic [7:0] rdata;
    logic irq;
  } state_s;

  state_s s_q, s_d;

  // Byte increment with wrap flag, used for both counter bytes
  function automatic logic [8:0] bump(input logic [7:0] v);
    bump = {1'b0, v} + 9'h001;
  endfunction

  function automatic logic [7:0] read_mux(input state_s s, input logic [7:0] a);
    unique case (a)
      CTRL_ADDR: read_mux = s.ctrl;
      RELOAD_LOW_ADDR: read_mux = s.reload_low;
      RELOAD_HIGH_ADDR: read_mux = s.reload_high;
      COUNT_LOW_ADDR: read_mux = s.count_low;
      COUNT_HIGH_ADDR: read_mux = s.count_high;
      default: read_mux = 8'h00;
    endcase
  endfunction

  // Register port decode shared by the byte and bit write paths
  function automatic logic ctrl_hit(input logic [7:0] a);
    ctrl_hit = (a == CTRL_ADDR);
  endfunction

  // Rising edge of a synchronised source against its delayed copy
  function automatic logic rise_of(input logic cur, input logic prev);
    rise_of = cur && !prev;
  endfunction

  // One step of an 8-bit auto-reload byte, returned as {wrapped, next value}
  function automatic logic [8:0] byte_step(input logic [7:0] v, input logic [7:0] reload);
    logic [8:0] sum;
    sum = bump(v);
    if (sum[8]) begin
      byte_step = {1'b1, reload};
    end else begin
      byte_step = {1'b0, sum[7:0]};
    end
  endfunction

  // Alternate count tick; code 10 falls back to the /12 source rather than stopping
  function automatic logic alt_pick(input logic [1:0] code, input logic div_in, cmp_in, rtc_in);
    unique case (code)
      SEL_DIV12_A: begin
        alt_pick = div_in;
      end
      SEL_CMP0: begin
        alt_pick = cmp_in;
      end
      SEL_DIV12_B: begin
        alt_pick = div_in;
      end
      SEL_RTC8: begin
        alt_pick = rtc_in;
      end
    endcase
  endfunction

  // Capture trigger: upper selector bit picks the comparator, else real-time clock /8
  function automatic logic cap_pick(input logic [1:0] code, input logic cmp_in, rtc_in);
    if (code[1]) begin
      cap_pick = cmp_in;
    end else begin
      cap_pick = rtc_in;
    end
  endfunction

  logic cmp_rise;
  logic rtc_rise;
  logic div12_tick;
  logic rtc8_tick;
  logic alt_tick;
  logic cap_tick;
  logic cap_event;
  logic low_tick;
  logic high_tick;
  logic low_wrap;
  logic high_wrap;
  logic capture;
  logic split;
  logic run;
  logic irq_cause;
  logic ctrl_byte_write;
  logic ctrl_bit_write;
  logic [8:0] low_sum;
  logic [8:0] high_sum;
  logic [8:0] low_step;
  logic [8:0] high_step;
  logic [7:0] ctrl_w;
  logic [7:0] read_value;
  logic [1:0] sel;

  always_comb begin
    s_d = s_q;
    split = s_q.ctrl[SPLIT_BIT];
    run = s_q.ctrl[RUN_BIT];
    capture = s_q.ctrl[CAPTURE_EN_BIT];
    sel = s_q.ctrl[1:0];

    // Only the second stage is examined; the first stage feeds nothing else
    s_d.cmp_sync = {s_q.cmp_sync[0], comparator0_out};
    s_d.rtc_sync = {s_q.rtc_sync[0], rtc_clock};
    s_d.cmp_prev = s_q.cmp_sync[1];
    s_d.rtc_prev = s_q.rtc_sync[1];
    cmp_rise = rise_of(s_q.cmp_sync[1], s_q.cmp_prev);
    rtc_rise = rise_of(s_q.rtc_sync[1], s_q.rtc_prev);

    // Divider runs free, so a selector change needs no restart
    div12_tick = (s_q.div12 == DIV12_LAST);
    if (div12_tick) begin
      s_d.div12 = 4'h0;
    end else begin
      s_d.div12 = s_q.div12 + 4'h1;
    end
    rtc8_tick = rtc_rise && (s_q.rtc_div == RTC_DIV_LAST);
    if (rtc_rise) begin
      s_d.rtc_div = s_q.rtc_div + 3'h1;
    end

    alt_tick = alt_pick(sel, div12_tick, cmp_rise, rtc8_tick);
    cap_tick = cap_pick(sel, cmp_rise, rtc8_tick);
    cap_event = capture && cap_tick;

    // Per-byte select picks core clock or the shared alternate tick
    low_tick = low_byte_fast_clock_select || alt_tick;
    high_tick = high_byte_fast_clock_select || alt_tick;

    low_sum = bump(s_q.count_low);
    high_sum = bump(s_q.count_high);
    low_step = byte_step(s_q.count_low, s_q.reload_low);
    high_step = byte_step(s_q.count_high, s_q.reload_high);
    low_wrap = 1'b0;
    high_wrap = 1'b0;
    ctrl_w = s_q.ctrl;

    if (split) begin
      // Low byte always counts in split mode
      if (low_tick) begin
        low_wrap = low_step[8];
        s_d.count_low = low_step[7:0];
      end
      if (run && high_tick) begin
        high_wrap = high_step[8];
        s_d.count_high = high_step[7:0];
      end
    end else if (run && low_tick) begin
      low_wrap = low_sum[8];
      s_d.count_low = low_sum[7:0];
      if (low_wrap) begin
        high_wrap = high_sum[8];
        s_d.count_high = high_sum[7:0];
      end
      // Capture mode runs through overflow so successive captures stay comparable
      if (high_wrap && !capture) begin
        s_d.count_low = s_q.reload_low;
        s_d.count_high = s_q.reload_high;
      end
    end

    // Software access; hardware sets below win over a same-cycle clear
    ctrl_byte_write = reg_write && ctrl_hit(reg_addr);
    ctrl_bit_write = bit_write && ctrl_hit(reg_addr) && !reg_write;
    if (ctrl_byte_write) begin
      ctrl_w = reg_wdata;
    end else if (ctrl_bit_write) begin
      ctrl_w[bit_index] = bit_value;
    end
    if (reg_write) begin
      unique case (reg_addr)
        RELOAD_LOW_ADDR: begin
          s_d.reload_low = reg_wdata;
        end
        RELOAD_HIGH_ADDR: begin
          s_d.reload_high = reg_wdata;
        end
        COUNT_LOW_ADDR: begin
          s_d.count_low = reg_wdata;
        end
        COUNT_HIGH_ADDR: begin
          s_d.count_high = reg_wdata;
        end
        default: ;
      endcase
    end

    // Capture copy wins over a software write to the reload pair
    if (cap_event) begin
      s_d.reload_low = s_q.count_low;
      s_d.reload_high = s_q.count_high;
    end

    // Flags only set here; clearing is by software alone
    if (high_wrap || cap_event) begin
      ctrl_w[HIGH_FLAG_BIT] = 1'b1;
    end
    if (low_wrap) begin
      ctrl_w[LOW_FLAG_BIT] = 1'b1;
    end
    s_d.ctrl = ctrl_w;

    // Request follows the next flag state, so it rises together with the flag
    irq_cause = ctrl_w[HIGH_FLAG_BIT];
    if (ctrl_w[LOW_IRQ_EN_BIT] && ctrl_w[LOW_FLAG_BIT]) begin
      irq_cause = 1'b1;
    end
    s_d.irq = timer_irq_enable && irq_cause;
    read_value = read_mux(s_q, reg_addr);
    if (reg_read) begin
      s_d.rdata = read_value;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign irq_request = s_q.irq;
  assign control_out = s_q.ctrl;

endmodule
`default_nettype wire

/* hw/timer_two_pkg.sv */
/*
  Package for the timer two control/status block: register addresses,
  control field positions, reset value, clock selector codes and divider counts.
  Assumes a single core clock domain and an 8-bit special function register port.
*/
package timer_two_pkg;
  localparam logic [7:0] CTRL_ADDR = 8'hc8;
  localparam logic [7:0] RELOAD_LOW_ADDR = 8'hca;
  localparam logic [7:0] RELOAD_HIGH_ADDR = 8'hcb;
  localparam logic [7:0] COUNT_LOW_ADDR = 8'hcc;
  localparam logic [7:0] COUNT_HIGH_ADDR = 8'hcd;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int HIGH_FLAG_BIT = 7;
  localparam int LOW_FLAG_BIT = 6;
  localparam int LOW_IRQ_EN_BIT = 5;
  localparam int CAPTURE_EN_BIT = 4;
  localparam int SPLIT_BIT = 3;
  localparam int RUN_BIT = 2;
  localparam logic [1:0] SEL_DIV12_A = 2'h0;
  localparam logic [1:0] SEL_CMP0 = 2'h1;
  localparam logic [1:0] SEL_DIV12_B = 2'h2;
  localparam logic [1:0] SEL_RTC8 = 2'h3;
  localparam logic [3:0] DIV12_LAST = 4'hb;
  localparam logic [2:0] RTC_DIV_LAST = 3'h7;
endpackage

/* tb/testbench.sv */
/*
  Self-checking bench for timer_two_ctrl.
  Assumes the package, design and checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import timer_two_pkg::*;
;
  logic clk = 0, reset = 1, reg_write = 0, reg_read = 0, bit_write = 0, bit_value = 0;
  logic hsel = 0, lsel = 0, irq_en = 0, cmp = 0, rtc = 0, irq_request;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, control_out, lfsr = 8'h54, v;
  logic [2:0] bit_index = 3'h0;
  int errors = 0, tests_run = 0;
  timer_two_ctrl u_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .bit_write(bit_write), .bit_index(bit_index),
    .bit_value(bit_value), .reg_rdata(reg_rdata), .high_byte_fast_clock_select(hsel),
    .low_byte_fast_clock_select(lsel), .timer_irq_enable(irq_en), .comparator0_out(cmp),
    .rtc_clock(rtc), .irq_request(irq_request), .control_out(control_out));
  initial begin
    forever #10 clk = ~clk;
  end
  // Slow source stepped just after core edges, one toggle every two cycles
  initial begin
    forever begin
      tick(2);
      rtc = ~rtc;
    end
  end
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1;
    tick(1);
    reg_write = 0;
    tick(1);
  endtask
  task automatic bw(input logic [2:0] i, input logic b);
    reg_addr = CTRL_ADDR;
    bit_index = i;
    bit_value = b;
    bit_write = 1;
    tick(1);
    bit_write = 0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_read = 1;
    tick(1);
    d = reg_rdata;
    reg_read = 0;
    tick(1);
  endtask
  task automatic final_report;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    final_report;
  end
  initial begin
    tick(20);
    reset = 0;
    tick(1);
    rd(CTRL_ADDR, v);
    chk(v, CTRL_RESET);
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      wr(CTRL_ADDR, lfsr & 8'h3b);
      rd(CTRL_ADDR, v);
      chk(v & 8'h3f, lfsr & 8'h3b);
    end
    wr(CTRL_ADDR, 8'h00);
    for (int i = 0; i < 6; i++) begin
      bw(i[2:0], 1'b1);
      chk(control_out & 8'h3f, (8'h02 << i) - 8'h01);
    end
    wr(CTRL_ADDR, 8'h20);
    // Second write lands with counting and capture already off, so no flag can race it
    wr(CTRL_ADDR, 8'h20);
    irq_en = 1;
    bw(3'h6, 1'b1);
    tick(2);
    chk({7'h00, irq_request}, 8'h01);
    bw(3'h6, 1'b0);
    tick(2);
    chk({7'h00, irq_request}, 8'h00);
    lsel = 1;
    hsel = 1;
    wr(RELOAD_HIGH_ADDR, 8'h12);
    wr(RELOAD_LOW_ADDR, 8'h34);
    wr(COUNT_LOW_ADDR, 8'hfe);
    wr(COUNT_HIGH_ADDR, 8'hff);
    wr(CTRL_ADDR, 8'h04);
    tick(4);
    chk(control_out & 8'hc0, 8'hc0);
    chk({7'h00, irq_request}, 8'h01);
    rd(COUNT_HIGH_ADDR, v);
    chk(v, 8'h12);
    wr(CTRL_ADDR, 8'h00);
    rd(COUNT_LOW_ADDR, lfsr);
    tick(5);
    rd(COUNT_LOW_ADDR, v);
    chk(v, lfsr);
    wr(COUNT_LOW_ADDR, 8'hfe);
    wr(COUNT_HIGH_ADDR, 8'hfe);
    wr(CTRL_ADDR, 8'h08);
    tick(4);
    chk(control_out, 8'h48);
    rd(COUNT_HIGH_ADDR, v);
    chk(v, 8'hfe);
    wr(CTRL_ADDR, 8'h0c);
    tick(4);
    chk(control_out & 8'h80, 8'h80);
    wr(CTRL_ADDR, 8'h16);
    tick(3);
    chk(control_out, 8'h16);
    cmp = 1;
    tick(8);
    chk(control_out & 8'h80, 8'h80);
    lsel = 0;
    cmp = 0;
    wr(CTRL_ADDR, 8'h00);
    wr(COUNT_LOW_ADDR, 8'hff);
    wr(CTRL_ADDR, 8'h05);
    tick(14);
    chk(control_out, 8'h05);
    cmp = 1;
    tick(6);
    chk(control_out & 8'h40, 8'h40);
    reset = 1;
    tick(2);
    chk(control_out, CTRL_RESET);
    reset = 0;
    tick(1);
    rd(COUNT_LOW_ADDR, v);
    chk(v, 8'h00);
    chk({7'h00, irq_request}, 8'h00);
    final_report;
  end
endmodule
`default_nettype wire

/* tb/timer_two_monitor.sv */
/*
  Checker for the timer two control block.
  Assumes one clock domain and the ports of timer_two_ctrl.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_two_monitor
  import timer_two_pkg::*;
(
  // Watched ports
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic bit_write,
  input wire logic [2:0] bit_index,
  input wire logic bit_value,
  input wire logic timer_irq_enable,
  input wire logic irq_request,
  input wire logic [7:0] control_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire logic hit = (reg_write | bit_write) && reg_addr == CTRL_ADDR;
  wire logic [7:0] c = control_out;
  ctrl_write_a: assert property (reg_write && hit |=> c[5:0] == $past(reg_wdata[5:0]))
    else $error("control write lost");
  bit_write_a: assert property (!reg_write && hit && bit_index < 3'h6 |=> c[$past(bit_index)] == $past(bit_value))
    else $error("bit write lost");
  ctrl_hold_a: assert property (!hit |=> $stable(c[5:0]))
    else $error("config bit changed alone");
  flag_sticky_a: assert property (!hit |=> (c[7:6] & $past(c[7:6])) == $past(c[7:6]))
    else $error("flag cleared by hardware");
  high_irq_a: assert property ((c[7] && timer_irq_enable)[*3] |-> irq_request)
    else $error("high flag gave no request");
  low_irq_a: assert property ((c[6] && c[5] && timer_irq_enable)[*3] |-> irq_request)
    else $error("low flag gave no request");
  irq_off_a: assert property ((!timer_irq_enable)[*2] |-> !irq_request)
    else $error("request while disabled");
  no_cause_a: assert property ((!c[7] && !(c[6] && c[5]))[*2] |-> !irq_request)
    else $error("request without cause");
  cover property ($rose(c[7]));
  cover property ($rose(irq_request));
  cover property (bit_write && hit);
endmodule
bind timer_two_ctrl timer_two_monitor u_mon (.*);
`default_nettype wire
